/* rtl/irt_consts.svh */
// Register map, field positions and reset values of the infrared timer.
// Assumes inclusion by bare name from the timer package and module.
`ifndef IRT_CONSTS_SVH
`define IRT_CONSTS_SVH

`define IRT_AW 8
`define IRT_ADDR_CTRL 8'h00
`define IRT_ADDR_CARRIER 8'h04
`define IRT_ADDR_MODTIME 8'h08
`define IRT_ADDR_VALUE 8'h0c
`define IRT_ADDR_STATUS 8'h10
`define IRT_ADDR_MASK 8'h14
`define IRT_ADDR_POWER 8'h18

`define IRT_CTRL_EN 0
`define IRT_CTRL_MODE 1
`define IRT_CTRL_FINE 2
`define IRT_CTRL_POL 3
`define IRT_CTRL_DATA 4
`define IRT_CTRL_RELOAD 5
`define IRT_CTRL_RISE 6
`define IRT_CTRL_FALL 7
`define IRT_CTRL_DIV_LO 8
`define IRT_CTRL_DIV_HI 10
`define IRT_CTRL_WMASK 16'h07ff

`define IRT_ST_IRQF 0
`define IRT_ST_OVF 1
`define IRT_PWR_LVL 0
`define IRT_PWR_OE 1

`define IRT_CTRL_RST 16'h0000
`define IRT_CARRIER_RST 16'h0000
`define IRT_MODTIME_RST 16'h0000
`define IRT_VALUE_RST 16'h0000
`define IRT_VALUE_MAX 16'hffff
`define IRT_VALUE_ZERO 16'h0000

`define IRT_RESP_OKAY 2'h0
`define IRT_RESP_SLVERR 2'h2

`endif

/* rtl/irt_pkg.sv */
// Types of the infrared carrier and modulation timer.
// Assumes the constants header is on the include path.
`include "irt_consts.svh"

package irt_pkg;

    typedef enum logic [1:0] {
        IRT_OFF,
        IRT_TX,
        IRT_RX
    } irt_mode_e;

    typedef struct packed {
        logic [`IRT_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`IRT_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } irt_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } irt_axi_rsp_s;

    typedef struct packed {
        irt_axi_rsp_s rsp;
        logic aw_have;
        logic [`IRT_AW-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [15:0] ctrl;
        logic [15:0] carrier;
        logic [15:0] modtime;
        logic [15:0] value;
        logic [1:0] status;
        logic [1:0] mask;
        logic [1:0] power;
        irt_mode_e mode;
        logic [6:0] pre_cnt;
        logic car_hi;
        logic [7:0] car_cnt;
        logic [15:0] car_l;
        logic data_l;
        logic pol_l;
        logic rx_prev;
        logic out;
        logic oe_n;
        logic irq;
    } irt_state_s;

endpackage : irt_pkg

/* rtl/irt_timer.sv */
// Infrared carrier generation and modulation timer with AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, and a receive pin
// already synchronous to CLK.
`timescale 1ns/100ps
`include "irt_consts.svh"

module irt_timer (
    input wire logic CLK,
    input wire logic RST_N,
    input wire irt_pkg::irt_axi_req_s AXI_REQ,
    output irt_pkg::irt_axi_rsp_s AXI_RSP,
    input wire logic INFRARED_IN_PIN,
    output logic INFRARED_OUT_PIN,
    output logic INFRARED_OUT_OE_N,
    output logic IRQ
);

    irt_pkg::irt_state_s state_reg;
    irt_pkg::irt_state_s state_next;

    logic en;
    logic tx;
    logic fine;
    logic [2:0] div;
    logic [6:0] div_mask;
    logic tick;
    logic car_end;
    logic cclk;
    logic run_tx;
    logic run_rx;
    logic rx_edge;
    logic st_wr;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    assign en = state_reg.ctrl[`IRT_CTRL_EN];
    assign tx = state_reg.ctrl[`IRT_CTRL_MODE];
    assign fine = state_reg.ctrl[`IRT_CTRL_FINE];
    assign div = state_reg.ctrl[`IRT_CTRL_DIV_HI:`IRT_CTRL_DIV_LO];
    // Prescaler fires when all counter bits below the divider are ones
    assign div_mask = 7'((8'h01 << div) - 8'h01);
    assign tick = &(state_reg.pre_cnt | ~div_mask);
    assign car_end = tick && !state_reg.car_hi
        && (state_reg.car_cnt == state_reg.car_l[7:0]);
    assign cclk = tick && (fine || car_end);
    assign run_tx = (state_reg.mode == irt_pkg::IRT_TX) && en && tx;
    assign run_rx = (state_reg.mode == irt_pkg::IRT_RX) && en && !tx;
    assign rx_edge = (state_reg.rx_prev != INFRARED_IN_PIN)
        && ((INFRARED_IN_PIN && state_reg.ctrl[`IRT_CTRL_RISE])
        || (!INFRARED_IN_PIN && state_reg.ctrl[`IRT_CTRL_FALL]));
    assign st_wr = state_reg.aw_have && state_reg.w_have
        && !state_reg.rsp.bvalid
        && (state_reg.aw_addr == `IRT_ADDR_STATUS);

    always_comb begin
        logic [1:0] st_set;
        logic [1:0] st_clr;
        logic [15:0] nv;
        state_next = state_reg;
        st_set = 2'h0;
        st_clr = 2'h0;
        nv = state_reg.value;

        // Write channels are accepted independently, held until both arrive
        if (state_reg.rsp.awready && AXI_REQ.awvalid) begin
            state_next.aw_have = 1'h1;
            state_next.aw_addr = AXI_REQ.awaddr;
            state_next.rsp.awready = 1'h0;
        end
        if (state_reg.rsp.wready && AXI_REQ.wvalid) begin
            state_next.w_have = 1'h1;
            state_next.w_data = AXI_REQ.wdata;
            state_next.w_strb = AXI_REQ.wstrb;
            state_next.rsp.wready = 1'h0;
        end
        if (state_reg.aw_have && state_reg.w_have && !state_reg.rsp.bvalid)
        begin
            state_next.aw_have = 1'h0;
            state_next.w_have = 1'h0;
            state_next.rsp.bvalid = 1'h1;
            state_next.rsp.bresp = `IRT_RESP_OKAY;
            unique case (state_reg.aw_addr)
                `IRT_ADDR_CTRL: begin
                    state_next.ctrl = merge16(state_reg.ctrl,
                        state_reg.w_data, state_reg.w_strb)
                        & `IRT_CTRL_WMASK;
                end
                `IRT_ADDR_CARRIER: begin
                    state_next.carrier = merge16(state_reg.carrier,
                        state_reg.w_data, state_reg.w_strb);
                end
                `IRT_ADDR_MODTIME: begin
                    state_next.modtime = merge16(state_reg.modtime,
                        state_reg.w_data, state_reg.w_strb);
                end
                `IRT_ADDR_VALUE: begin
                end
                `IRT_ADDR_STATUS: begin
                    if (state_reg.w_strb[0]) begin
                        st_clr = state_reg.w_data[1:0];
                    end
                end
                `IRT_ADDR_MASK: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.mask = state_reg.w_data[1:0];
                    end
                end
                `IRT_ADDR_POWER: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.power = state_reg.w_data[1:0];
                    end
                end
                default: begin
                    state_next.rsp.bresp = `IRT_RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rsp.bvalid && AXI_REQ.bready) begin
            state_next.rsp.bvalid = 1'h0;
            state_next.rsp.awready = 1'h1;
            state_next.rsp.wready = 1'h1;
        end

        if (state_reg.rsp.arready && AXI_REQ.arvalid) begin
            state_next.rsp.arready = 1'h0;
            state_next.rsp.rvalid = 1'h1;
            state_next.rsp.rresp = `IRT_RESP_OKAY;
            state_next.rsp.rdata = 32'h0;
            unique case (AXI_REQ.araddr)
                `IRT_ADDR_CTRL: state_next.rsp.rdata[15:0] = state_reg.ctrl;
                `IRT_ADDR_CARRIER: begin
                    state_next.rsp.rdata[15:0] = state_reg.carrier;
                end
                `IRT_ADDR_MODTIME: begin
                    state_next.rsp.rdata[15:0] = state_reg.modtime;
                end
                `IRT_ADDR_VALUE: begin
                    state_next.rsp.rdata[15:0] = state_reg.value;
                end
                `IRT_ADDR_STATUS: begin
                    state_next.rsp.rdata[1:0] = state_reg.status;
                end
                `IRT_ADDR_MASK: state_next.rsp.rdata[1:0] = state_reg.mask;
                `IRT_ADDR_POWER: begin
                    state_next.rsp.rdata[1:0] = state_reg.power;
                end
                default: state_next.rsp.rresp = `IRT_RESP_SLVERR;
            endcase
        end
        if (state_reg.rsp.rvalid && AXI_REQ.rready) begin
            state_next.rsp.rvalid = 1'h0;
            state_next.rsp.arready = 1'h1;
        end

        state_next.pre_cnt = state_reg.pre_cnt + 7'h1;
        // Carrier phase: high for high byte plus one, low for low byte plus one
        if (tick) begin
            if (state_reg.car_hi) begin
                if (state_reg.car_cnt == state_reg.car_l[15:8]) begin
                    state_next.car_hi = 1'h0;
                    state_next.car_cnt = 8'h0;
                end else begin
                    state_next.car_cnt = state_reg.car_cnt + 8'h1;
                end
            end else if (car_end) begin
                state_next.car_hi = 1'h1;
                state_next.car_cnt = 8'h0;
            end else begin
                state_next.car_cnt = state_reg.car_cnt + 8'h1;
            end
        end

        unique case (state_reg.mode)
            irt_pkg::IRT_OFF: begin
                // Prescaler restarts so the first interval is full length
                state_next.pre_cnt = 7'h0;
                state_next.car_hi = 1'h1;
                state_next.car_cnt = 8'h0;
                state_next.car_l = state_reg.carrier;
                state_next.rx_prev = INFRARED_IN_PIN;
                if (en && tx) begin
                    state_next.mode = irt_pkg::IRT_TX;
                    state_next.value = state_reg.modtime;
                    state_next.data_l = state_reg.ctrl[`IRT_CTRL_DATA];
                    state_next.pol_l = state_reg.ctrl[`IRT_CTRL_POL];
                end else if (en) begin
                    state_next.mode = irt_pkg::IRT_RX;
                end
            end
            irt_pkg::IRT_TX: begin
                if (!run_tx) begin
                    state_next.mode = irt_pkg::IRT_OFF;
                end else if (cclk) begin
                    if (state_reg.value == `IRT_VALUE_ZERO) begin
                        state_next.value = state_reg.modtime;
                        // Resampled carrier restarts its phase to stay bounded
                        state_next.car_l = state_reg.carrier;
                        state_next.data_l = state_reg.ctrl[`IRT_CTRL_DATA];
                        state_next.pol_l = state_reg.ctrl[`IRT_CTRL_POL];
                        state_next.car_hi = 1'h1;
                        state_next.car_cnt = 8'h0;
                        st_set[`IRT_ST_IRQF] = 1'h1;
                    end else begin
                        state_next.value = state_reg.value - 16'h1;
                    end
                end
            end
            irt_pkg::IRT_RX: begin
                state_next.rx_prev = INFRARED_IN_PIN;
                if (!run_rx) begin
                    state_next.mode = irt_pkg::IRT_OFF;
                end else begin
                    if (car_end) begin
                        state_next.car_l = state_reg.carrier;
                    end
                    if (cclk) begin
                        nv = state_reg.value + 16'h1;
                        if (state_reg.value == `IRT_VALUE_MAX) begin
                            st_set[`IRT_ST_OVF] = 1'h1;
                        end
                    end
                    if (rx_edge) begin
                        state_next.ctrl[`IRT_CTRL_DATA] = INFRARED_IN_PIN;
                        state_next.modtime = state_reg.value;
                        st_set[`IRT_ST_IRQF] = 1'h1;
                        if (state_reg.ctrl[`IRT_CTRL_RELOAD]) begin
                            nv = `IRT_VALUE_ZERO;
                        end
                    end
                    state_next.value = nv;
                end
            end
        endcase

        // A hardware set in the same cycle as a clear wins
        state_next.status = (state_reg.status & ~st_clr) | st_set;

        if (state_next.mode == irt_pkg::IRT_TX) begin
            state_next.out = state_next.pol_l
                ^ (state_next.data_l & state_next.car_hi);
            state_next.oe_n = 1'h0;
        end else if (state_next.ctrl[`IRT_CTRL_EN]) begin
            state_next.out = state_next.ctrl[`IRT_CTRL_POL];
            state_next.oe_n = 1'h0;
        end else begin
            state_next.out = state_next.power[`IRT_PWR_LVL];
            state_next.oe_n = !state_next.power[`IRT_PWR_OE];
        end
        state_next.irq = |(state_next.status & state_next.mask);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= '0;
            state_reg.rsp.awready <= 1'h1;
            state_reg.rsp.wready <= 1'h1;
            state_reg.rsp.arready <= 1'h1;
            state_reg.ctrl <= `IRT_CTRL_RST;
            state_reg.carrier <= `IRT_CARRIER_RST;
            state_reg.modtime <= `IRT_MODTIME_RST;
            state_reg.value <= `IRT_VALUE_RST;
            state_reg.mode <= irt_pkg::IRT_OFF;
            state_reg.car_hi <= 1'h1;
            state_reg.oe_n <= 1'h1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign AXI_RSP = state_reg.rsp;
    assign INFRARED_OUT_PIN = state_reg.out;
    assign INFRARED_OUT_OE_N = state_reg.oe_n;
    assign IRQ = state_reg.irq;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_manual_pin;
        (!state_next.ctrl[`IRT_CTRL_EN]
            && state_next.mode == irt_pkg::IRT_OFF)
        |=> (INFRARED_OUT_PIN == $past(state_next.power[`IRT_PWR_LVL]))
            && (INFRARED_OUT_OE_N == !$past(state_next.power[`IRT_PWR_OE]));
    endproperty
    a_manual_pin: assert property (p_manual_pin)
        else $error("manual pin control not followed");

    property p_prescale;
        (tick && div != 3'h0) |=> !tick || (div != $past(div));
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("divided input clock ticked twice in a row");

    property p_tx_pin;
        (state_reg.mode == irt_pkg::IRT_TX) |-> !INFRARED_OUT_OE_N
            && (INFRARED_OUT_PIN
            == (state_reg.pol_l ^ (state_reg.data_l & state_reg.car_hi)));
    endproperty
    a_tx_pin: assert property (p_tx_pin)
        else $error("transmit pin does not match modulated carrier");

    property p_start;
        (state_reg.mode == irt_pkg::IRT_OFF && en && tx)
        |=> (state_reg.mode == irt_pkg::IRT_TX)
            && (state_reg.value == $past(state_reg.modtime))
            && (state_reg.pol_l == $past(state_reg.ctrl[`IRT_CTRL_POL]));
    endproperty
    a_start: assert property (p_start)
        else $error("transmission did not start with sampled settings");

    property p_down;
        (run_tx && cclk && state_reg.value != `IRT_VALUE_ZERO)
        |=> state_reg.value == $past(state_reg.value) - 16'h1;
    endproperty
    a_down: assert property (p_down)
        else $error("transmit counter did not count down");

    property p_reload;
        (run_tx && cclk && state_reg.value == `IRT_VALUE_ZERO)
        |=> (state_reg.value == $past(state_reg.modtime))
            && (state_reg.car_l == $past(state_reg.carrier))
            && state_reg.status[`IRT_ST_IRQF] ##1 IRQ == state_reg.mask[0];
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload at zero incomplete");

    property p_carrier_high;
        (run_tx && tick && state_reg.car_hi && !(cclk && state_reg.value
            == `IRT_VALUE_ZERO)
            && state_reg.car_cnt == state_reg.car_l[15:8])
        |=> !state_reg.car_hi && state_reg.car_cnt == 8'h0;
    endproperty
    a_carrier_high: assert property (p_carrier_high)
        else $error("carrier high time wrong");

    property p_carrier_hold;
        (run_tx && !(cclk && state_reg.value == `IRT_VALUE_ZERO))
        |=> state_reg.car_l == $past(state_reg.car_l);
    endproperty
    a_carrier_hold: assert property (p_carrier_hold)
        else $error("carrier setting changed inside an interval");

    property p_stop;
        (state_reg.mode == irt_pkg::IRT_TX && (!en || !tx))
        |=> state_reg.mode == irt_pkg::IRT_OFF;
    endproperty
    a_stop: assert property (p_stop)
        else $error("transmission not terminated");

    property p_overflow;
        (run_rx && cclk && state_reg.value == `IRT_VALUE_MAX)
        |=> state_reg.status[`IRT_ST_OVF];
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow flag not set on rollover");

    property p_capture;
        (run_rx && rx_edge)
        |=> (state_reg.modtime == $past(state_reg.value))
            && (state_reg.ctrl[`IRT_CTRL_DATA] == $past(INFRARED_IN_PIN));
    endproperty
    a_capture: assert property (p_capture)
        else $error("receive capture lost");

    property p_sticky;
        (state_reg.status[`IRT_ST_IRQF] && !st_wr)
        |=> state_reg.status[`IRT_ST_IRQF];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("timer flag dropped without software clear");

    c_reload: cover property (run_tx && cclk
        && state_reg.value == `IRT_VALUE_ZERO);
    c_capture: cover property (run_rx && rx_edge);
    c_overflow: cover property (run_rx && cclk
        && state_reg.value == `IRT_VALUE_MAX);
    c_irq: cover property (!IRQ ##1 IRQ);

endmodule : irt_timer

/* testbench/irt_ir_partner.sv */
// Model of the emitter driver and receiver around the infrared timer.
// Assumes the bench sets the receiver level on clock edges.
`timescale 1ns/100ps

module irt_ir_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_pin,
    input wire logic tx_oe_n,
    input wire logic rx_level,
    output logic rx_pin,
    output logic [15:0] hi_run,
    output logic [15:0] lo_run
);
    logic [15:0] run_reg;
    logic prev_reg;

    // The receiver always drives its output, so no released state exists
    assign rx_pin = rx_level;

    // Emitter records the last complete lit and dark run lengths;
    // runs restart whenever the driver is released
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_run <= 16'h0000;
            lo_run <= 16'h0000;
        end
        if (!rst_n || tx_oe_n) begin
            run_reg <= 16'h0001;
            prev_reg <= tx_pin;
        end else if (tx_pin == prev_reg) begin
            run_reg <= run_reg + 16'h0001;
        end else begin
            if (prev_reg) hi_run <= run_reg;
            else lo_run <= run_reg;
            run_reg <= 16'h0001;
            prev_reg <= tx_pin;
        end
    end

endmodule : irt_ir_partner

/* testbench/irt_timer_test.sv */
// Self-checking bench of the infrared timer: register access, transmit
// waveforms, receive capture, flags and interrupt.
// Assumes the timer package, constants header and partner model.
`timescale 1ns/100ps
`include "irt_consts.svh"

module irt_timer_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    irt_pkg::irt_axi_req_s req = '0;
    irt_pkg::irt_axi_rsp_s rsp;
    logic out_pin, out_oe_n, irq, rx_pin;
    logic rx_level = 1'b0;
    logic [15:0] hi_run, lo_run;
    logic [31:0] rv, rv2;
    logic [1:0] resp;
    int mismatches = 0;
    int cmp_count = 0;
    int h, l, d, m, t;

    always #2.5 clk = ~clk;

    irt_timer u_dut (.CLK(clk), .RST_N(rst_n), .AXI_REQ(req), .AXI_RSP(rsp),
        .INFRARED_IN_PIN(rx_pin), .INFRARED_OUT_PIN(out_pin),
        .INFRARED_OUT_OE_N(out_oe_n), .IRQ(irq));
    irt_ir_partner u_ir (.clk(clk), .rst_n(rst_n), .tx_pin(out_pin),
        .tx_oe_n(out_oe_n), .rx_level(rx_level), .rx_pin(rx_pin),
        .hi_run(hi_run), .lo_run(lo_run));

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    // Address and data are offered together; the slave may take either first
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        resp = rsp.bresp;
        req.bready <= 1'b0;
        if (n == 50) begin
            mismatches++;
            summarize();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rv = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        if (n == 50) begin
            mismatches++;
            summarize();
        end
    endtask : axi_rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic steady(input logic lvl);
        repeat (16) begin
            @(posedge clk);
            chk(32'(out_pin), 32'(lvl));
        end
    endtask : steady

    // Control word: f = {data, polarity, fine, mode, enable}
    function automatic logic [31:0] ctl(input int dv, input logic [4:0] f);
        return {21'h0, dv[2:0], 3'h0, f};
    endfunction : ctl

    // Expected pin run in system clocks for a number of input clock ticks
    function automatic logic [31:0] exp_run(input int ticks, input int dv);
        return 32'(ticks << dv);
    endfunction : exp_run

    initial begin
        void'($urandom(55860));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({irq, out_oe_n, out_pin}, 32'h2);
        axi_rd(`IRT_ADDR_CTRL);
        chk(rv, 32'h0);
        axi_wr(`IRT_ADDR_POWER, 32'h3);
        cyc(3);
        chk({out_oe_n, out_pin}, 32'h1);
        axi_wr(`IRT_ADDR_POWER, 32'h2);
        cyc(3);
        chk({out_oe_n, out_pin}, 32'h0);
        axi_rd(8'h1c);
        chk(resp, `IRT_RESP_SLVERR);
        chk(rv, 32'h0);
        axi_wr(8'h1c, 32'h1);
        chk(resp, `IRT_RESP_SLVERR);
        axi_wr(`IRT_ADDR_VALUE, 32'hffff);
        chk(resp, `IRT_RESP_OKAY);
        axi_rd(`IRT_ADDR_VALUE);
        chk(rv, 32'h0);
        axi_wr(`IRT_ADDR_POWER, 32'h0);
        // Carrier timing, both polarities and all three ways of starting
        for (int i = 0; i < 4; i++) begin
            h = $urandom_range(7);
            l = $urandom_range(7);
            d = $urandom_range(3);
            axi_wr(`IRT_ADDR_CARRIER, 32'({h[7:0], l[7:0]}));
            if (i == 1) axi_wr(`IRT_ADDR_CTRL, ctl(d, 5'b10001));
            if (i == 2) axi_wr(`IRT_ADDR_CTRL, ctl(d, 5'b10010));
            axi_wr(`IRT_ADDR_CTRL, ctl(d, {1'b1, i[0], 3'b011}));
            cyc(600);
            chk(hi_run, exp_run((i[0] ? l : h) + 1, d));
            chk(lo_run, exp_run((i[0] ? h : l) + 1, d));
            axi_wr(`IRT_ADDR_CTRL, 32'h0);
            cyc(3);
            chk(out_oe_n, 32'h1);
        end
        // Fine counting: one lit tick per interval, dark for the rest
        d = $urandom_range(2);
        m = $urandom_range(20, 2);
        axi_wr(`IRT_ADDR_CARRIER, 32'h00ff);
        axi_wr(`IRT_ADDR_MODTIME, 32'(m));
        axi_wr(`IRT_ADDR_CTRL, ctl(d, 5'b10111));
        cyc(400);
        chk(hi_run, exp_run(1, d));
        chk(lo_run, exp_run(m, d));
        // New carrier written mid-run takes effect from the next interval
        axi_wr(`IRT_ADDR_CARRIER, 32'h01ff);
        cyc(200);
        chk(hi_run, exp_run(2, d));
        chk(lo_run, exp_run(m - 1, d));
        axi_wr(`IRT_ADDR_CTRL, ctl(d, 5'b11101));
        cyc(3);
        steady(1'b1);
        axi_wr(`IRT_ADDR_CTRL, ctl(d, 5'b01111));
        cyc(3);
        steady(1'b1);
        axi_wr(`IRT_ADDR_CTRL, 32'h0);
        axi_rd(`IRT_ADDR_STATUS);
        chk(rv, 32'h1);
        cyc(20);
        axi_rd(`IRT_ADDR_STATUS);
        chk(rv, 32'h1);
        chk(irq, 32'h0);
        axi_wr(`IRT_ADDR_MASK, 32'h1);
        cyc(3);
        chk(irq, 32'h1);
        axi_wr(`IRT_ADDR_STATUS, 32'h1);
        cyc(3);
        chk(irq, 32'h0);
        // Receive: capture on rising edges only, counter restarts at zero
        axi_wr(`IRT_ADDR_CTRL, 32'h0065);
        t = $urandom_range(200, 50);
        cyc(5);
        rx_level <= 1'b1;
        cyc(t);
        rx_level <= 1'b0;
        cyc(10);
        rx_level <= 1'b1;
        cyc(5);
        axi_rd(`IRT_ADDR_MODTIME);
        chk(32'(rv[15:0] >= t + 8 && rv[15:0] <= t + 12), 32'h1);
        axi_rd(`IRT_ADDR_CTRL);
        chk(rv[4], 32'h1);
        axi_rd(`IRT_ADDR_VALUE);
        rv2 = rv;
        axi_rd(`IRT_ADDR_VALUE);
        chk(32'(rv[15:0] > rv2[15:0]), 32'h1);
        // Falling-edge capture clears the data bit written as one
        axi_wr(`IRT_ADDR_CTRL, 32'h00b5);
        rx_level <= 1'b0;
        cyc(5);
        axi_rd(`IRT_ADDR_CTRL);
        chk(rv[4], 32'h0);
        // Free-running receive count must wrap and raise the overflow flag
        axi_wr(`IRT_ADDR_CTRL, 32'h0045);
        axi_wr(`IRT_ADDR_STATUS, 32'h3);
        axi_wr(`IRT_ADDR_MASK, 32'h2);
        cyc(65540);
        axi_rd(`IRT_ADDR_STATUS);
        chk(rv[1], 32'h1);
        chk(irq, 32'h1);
        summarize();
    end

endmodule : irt_timer_test
